// ===== hw/pcio_pkg.sv
// Purpose: shared constants of the eight-pin port with serial pin sharing
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   offsets are byte addresses

package pcio_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned PORT_W = 8;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [4:0] OFS_DIRECTION = 5'h00; // direction_bits, write only
    localparam logic [4:0] OFS_OUT_DATA  = 5'h04; // output_data_bits
    localparam logic [4:0] OFS_READBACK  = 5'h08; // pin_level_readback, read only
    localparam logic [4:0] OFS_PULLUP    = 5'h0c; // input_pullup_enable
    localparam logic [4:0] OFS_OPEN_DRN  = 5'h10; // open_drain_select

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_OUT_DATA  = 8'h00;
    localparam logic [7:0] RST_PULLUP    = 8'h00;
    localparam logic [7:0] RST_OPEN_DRN  = 8'h00;
    localparam logic [7:0] DIR_READ_VAL  = 8'h00; // value shown for the write-only register

    // ****************************************
    // pin positions within one serial channel, and the interrupt pin numbers
    // ****************************************
    localparam int unsigned CH_PINS   = 3; // pins used per channel
    localparam int unsigned POS_TX    = 0; // transmit data pin
    localparam int unsigned POS_RX    = 1; // receive data pin
    localparam int unsigned POS_SCK   = 2; // serial clock pin
    localparam int unsigned EXT_INT5_PIN = 5;
    localparam int unsigned EXT_INT4_PIN = 2;

    // ****************************************
    // bus responses
    // ****************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== hw/pcio_port.sv
// Purpose: eight-pin general-purpose port with serial and interrupt sharing
// Assumes: serial controls come from logic on aclk; pins are asynchronous
// Notes:   pin outputs are combinational from registers and serial drive
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.

`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R1 - readback: output bits give data, inputs give pins
// R2 - readback register ignores writes entirely
// R3 - readback after reset follows the pin levels
// R4 - pull-up bit 1 enables pull-up on inputs
// R5 - pull-up register read/write, resets to zero
// R6 - open-drain drives low only, pull-up off
// R7 - open-drain bit 0 means push-pull; resets zero
// R8 - pins 7, 6 plain input or output
// R9 - pin 5 serial clock in, out, else general
// R10 - pin 4 receive enable gives receive input
// R11 - pin 3 transmit enable drives transmit data
// R12 - pin 2 serial clock in, out, else general
// R13 - pin 1 receive enable gives receive input
// R14 - pin 0 transmit enable drives transmit data
// R15 - pins 5, 2 feed interrupts when inputs (here only as general inputs, not as serial clock inputs)
// R16 - direction write-only, resets to inputs
// R17 - output data register read/write, resets zero
// R18 - pull-up only on general inputs
module pcio_port (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          ce,
    // axi4-lite slave
    input  wire logic [pcio_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [pcio_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [pcio_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [pcio_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // serial channel controls, index is channel
    input  wire logic [1:0]                    clock_enable_high,
    input  wire logic [1:0]                    clock_enable_low,
    input  wire logic [1:0]                    sync_mode,
    input  wire logic [1:0]                    receive_enable,
    input  wire logic [1:0]                    transmit_enable,
    input  wire logic [1:0]                    ser_clock_drive,
    input  wire logic [1:0]                    ser_transmit_data,
    output logic [1:0]                         ser_clock_sense,
    output logic [1:0]                         ser_receive_data,
    output logic                               ext_interrupt5,
    output logic                               ext_interrupt4,
    // port pins
    input  wire logic [pcio_pkg::PORT_W-1:0]   port_pin_i,
    output logic [pcio_pkg::PORT_W-1:0]        port_pin_o,
    output logic [pcio_pkg::PORT_W-1:0]        port_pin_oe,
    output logic [pcio_pkg::PORT_W-1:0]        pullup_on
);

    // ****************************************
    // pin synchroniser
    // ****************************************
    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;

    // two stages, no reset so levels flow straight after reset
    always_ff @(posedge aclk) begin
        if (ce) begin
            pin_meta_q <= port_pin_i;
            pin_sync_q <= pin_meta_q; // R3
        end
    end

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] direction_bits_q, direction_bits_d;
    logic [7:0] output_data_bits_q, output_data_bits_d;
    logic [7:0] input_pullup_enable_q, input_pullup_enable_d;
    logic [7:0] open_drain_select_q, open_drain_select_d;
    logic [7:0] pin_level_readback;

    // ****************************************
    // pin function select
    // ****************************************
    logic [7:0] func_in;
    logic [7:0] func_drv;
    logic [7:0] func_val;
    logic [7:0] gen_in;
    logic [7:0] gen_out;
    logic [7:0] drive;
    logic [7:0] drive_val;

    // serial functions override the direction bit per channel
    always_comb begin
        func_in  = 8'h00;
        func_drv = 8'h00;
        func_val = 8'h00;
        for (int c = 0; c < 2; c++) begin
            // serial clock: input beats output beats general
            if (clock_enable_high[c]) begin
                func_in[c*pcio_pkg::CH_PINS+pcio_pkg::POS_SCK] = 1'b1; // R9 R12
            end else if (sync_mode[c] || clock_enable_low[c]) begin
                func_drv[c*pcio_pkg::CH_PINS+pcio_pkg::POS_SCK] = 1'b1; // R9 R12
                func_val[c*pcio_pkg::CH_PINS+pcio_pkg::POS_SCK] = ser_clock_drive[c];
            end
            // receive data ignores direction
            func_in[c*pcio_pkg::CH_PINS+pcio_pkg::POS_RX] = receive_enable[c]; // R10 R13
            // transmit data ignores direction
            func_drv[c*pcio_pkg::CH_PINS+pcio_pkg::POS_TX] = transmit_enable[c]; // R11 R14
            func_val[c*pcio_pkg::CH_PINS+pcio_pkg::POS_TX] = ser_transmit_data[c];
        end
    end

    // general use where no serial function claims the pin
    assign gen_out   = direction_bits_q & ~(func_in | func_drv); // R8
    assign gen_in    = ~direction_bits_q & ~(func_in | func_drv); // R8
    assign drive     = gen_out | func_drv;
    assign drive_val = (gen_out & output_data_bits_q) | (func_drv & func_val); // R17

    // open drain releases a high, push-pull drives both levels
    assign port_pin_oe = drive & ~(open_drain_select_q & drive_val); // R6 R7
    assign port_pin_o  = drive_val & ~open_drain_select_q; // R6

    // pull-up only on general inputs; outputs never pull up
    assign pullup_on = input_pullup_enable_q & gen_in; // R4 R18

    // pins handed to the serial and interrupt logic
    assign ser_clock_sense  = {pin_sync_q[5], pin_sync_q[2]};
    assign ser_receive_data = {pin_sync_q[4], pin_sync_q[1]};
    assign ext_interrupt5   = gen_in[pcio_pkg::EXT_INT5_PIN] ? pin_sync_q[5] : 1'b1; // R15
    assign ext_interrupt4   = gen_in[pcio_pkg::EXT_INT4_PIN] ? pin_sync_q[2] : 1'b1; // R15

    // readback mixes stored data and live pins
    assign pin_level_readback = (direction_bits_q & output_data_bits_q)
                              | (~direction_bits_q & pin_sync_q); // R1

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    logic                      aw_held_q, aw_held_d;
    logic [pcio_pkg::ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic                      w_held_q, w_held_d;
    logic [7:0]                w_data_q, w_data_d;
    logic                      w_lane0_q, w_lane0_d;
    logic                      bvalid_q, bvalid_d;
    logic [1:0]                bresp_q, bresp_d;
    logic                      do_write;

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = ~w_held_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign do_write      = aw_held_q & w_held_q & ~bvalid_q;

    // catch address and data in either order, answer once both held
    always_comb begin
        aw_held_d             = aw_held_q;
        aw_addr_d             = aw_addr_q;
        w_held_d              = w_held_q;
        w_data_d              = w_data_q;
        w_lane0_d             = w_lane0_q;
        bvalid_d              = bvalid_q;
        bresp_d               = bresp_q;
        direction_bits_d      = direction_bits_q;
        output_data_bits_d    = output_data_bits_q;
        input_pullup_enable_d = input_pullup_enable_q;
        open_drain_select_d   = open_drain_select_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d  = 1'b1;
            w_data_d  = s_axi_wdata[7:0];
            w_lane0_d = s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = pcio_pkg::RESP_OKAY;
            case (aw_addr_q)
                pcio_pkg::OFS_DIRECTION: begin
                    if (w_lane0_q) direction_bits_d = w_data_q; // R16
                end
                pcio_pkg::OFS_OUT_DATA: begin
                    if (w_lane0_q) output_data_bits_d = w_data_q; // R17
                end
                pcio_pkg::OFS_READBACK: begin
                    bresp_d = pcio_pkg::RESP_OKAY; // R2
                end
                pcio_pkg::OFS_PULLUP: begin
                    if (w_lane0_q) input_pullup_enable_d = w_data_q; // R5
                end
                pcio_pkg::OFS_OPEN_DRN: begin
                    if (w_lane0_q) open_drain_select_d = w_data_q; // R7
                end
                default: begin
                    bresp_d = pcio_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // write state and port registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q             <= 1'b0;
            aw_addr_q             <= '0;
            w_held_q              <= 1'b0;
            w_data_q              <= 8'h00;
            w_lane0_q             <= 1'b0;
            bvalid_q              <= 1'b0;
            bresp_q               <= pcio_pkg::RESP_OKAY;
            direction_bits_q      <= pcio_pkg::RST_DIRECTION; // R16
            output_data_bits_q    <= pcio_pkg::RST_OUT_DATA; // R17
            input_pullup_enable_q <= pcio_pkg::RST_PULLUP; // R5
            open_drain_select_q   <= pcio_pkg::RST_OPEN_DRN; // R7
        end else if (ce) begin
            aw_held_q             <= aw_held_d;
            aw_addr_q             <= aw_addr_d;
            w_held_q              <= w_held_d;
            w_data_q              <= w_data_d;
            w_lane0_q             <= w_lane0_d;
            bvalid_q              <= bvalid_d;
            bresp_q               <= bresp_d;
            direction_bits_q      <= direction_bits_d;
            output_data_bits_q    <= output_data_bits_d;
            input_pullup_enable_q <= input_pullup_enable_d;
            open_drain_select_q   <= open_drain_select_d;
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    logic        rvalid_q, rvalid_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = {24'h000000, rdata_q};
    assign s_axi_rresp   = rresp_q;

    // one read at a time, answer the cycle after the address
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = pcio_pkg::RESP_OKAY;
            case (s_axi_araddr)
                pcio_pkg::OFS_DIRECTION: rdata_d = pcio_pkg::DIR_READ_VAL; // R16
                pcio_pkg::OFS_OUT_DATA:  rdata_d = output_data_bits_q;
                pcio_pkg::OFS_READBACK:  rdata_d = pin_level_readback; // R1
                pcio_pkg::OFS_PULLUP:    rdata_d = input_pullup_enable_q;
                pcio_pkg::OFS_OPEN_DRN:  rdata_d = open_drain_select_q;
                default: begin
                    rdata_d = 8'h00;
                    rresp_d = pcio_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // read response registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 8'h00;
            rresp_q  <= pcio_pkg::RESP_OKAY;
        end else if (ce) begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    readback_read_a: assert property (s_axi_arvalid && s_axi_arready && ce // R1
        && s_axi_araddr == pcio_pkg::OFS_READBACK |=> s_axi_rdata[7:0] == $past(pin_level_readback))
        else $error("readback answer wrong");
    readback_ro_a: assert property (do_write && ce // R2
        && aw_addr_q == pcio_pkg::OFS_READBACK |=> $stable(direction_bits_q)
        && $stable(output_data_bits_q) && $stable(input_pullup_enable_q)
        && $stable(open_drain_select_q))
        else $error("readback write changed state");
    pullup_reset_a: assert property ($rose(aresetn) |-> input_pullup_enable_q == 8'h00 // R5
        && open_drain_select_q == 8'h00 && direction_bits_q == 8'h00)
        else $error("control registers not cleared");
    pullup_gate_a: assert property (pullup_on[7] |-> !port_pin_oe[7] && !direction_bits_q[7]) // R18
        else $error("pull-up on a driven pin");
    open_drain_a: assert property (|(port_pin_oe & open_drain_select_q) // R6
        |-> (port_pin_o & open_drain_select_q) == 8'h00)
        else $error("open drain drove high");
    pin7_out_a: assert property (direction_bits_q[7] && !open_drain_select_q[7] // R8
        |-> port_pin_oe[7] && port_pin_o[7] == output_data_bits_q[7])
        else $error("pin 7 output wrong");
    rx_in_a: assert property (receive_enable[1] |-> !port_pin_oe[4]) // R10
        else $error("receive pin driven");
    tx_out_a: assert property (transmit_enable[1] && !open_drain_select_q[3] // R11
        |-> port_pin_oe[3] && port_pin_o[3] == ser_transmit_data[1])
        else $error("transmit pin wrong");
    sck_in_a: assert property (clock_enable_high[0] |-> !port_pin_oe[2] && !pullup_on[2]) // R12
        else $error("clock input driven");
    irq_idle_a: assert property (direction_bits_q[5] |-> ext_interrupt5) // R15
        else $error("interrupt from output pin");
    write_resp_a: assert property (do_write && ce |=> s_axi_bvalid) // R16
        else $error("write not answered");

endmodule

`default_nettype wire

// ===== verification/pcio_pin_model.sv
// Purpose: outside circuitry on the eight port pins
// Assumes: bench may also drive pins that the port drives; port drive wins
// Notes:   a floating pin toggles every cycle so no stale level is read
`timescale 1ns/1ns
`default_nettype none
module pcio_pin_model (
    input  wire logic       aclk,
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_on,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic [7:0]      pin_level
);
    logic [7:0] last_q = 8'h00;
    // last level, inverted while nobody drives the pin
    always_ff @(posedge aclk) begin
        last_q <= pin_level;
    end
    // port drive wins, then outside drive, then pull-up, else float
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // unknown drive before reset counts as released, keeps levels known
            pin_level[i] = (pin_oe[i] === 1'h1) ? pin_o[i] : ext_en[i] ? ext_val[i] :
                           (pullup_on[i] === 1'h1) ? 1'h1 : ~last_q[i];
        end
    end
endmodule
`default_nettype wire

// ===== verification/pcio_port_tb_top.sv
// Purpose: register and pin-function tests of the port
// Assumes: AXI4-Lite master tasks, pins seen through the pin model
// Notes:   synced inputs are checked three cycles after a change
`timescale 1ns/1ns
`default_nettype none
module pcio_port_tb_top;
    logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, sck_sense, rxd;
    logic [1:0]  ceh = 2'h0, cel = 2'h0, syncm = 2'h0, rxen = 2'h0, txen = 2'h0;
    logic [1:0]  sck_drv = 2'h0, txd = 2'h0;
    logic        ei5, ei4;
    logic [7:0]  pin_i, pin_o, pin_oe, pull_on, ext_en = 8'h00, ext_val = 8'h00;
    int          err_count = 0, checks_done = 0, cycles = 0, b;
    localparam logic [1:0] OK = pcio_pkg::RESP_OKAY;

    pcio_port pcio_port_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .clock_enable_high(ceh), .clock_enable_low(cel), .sync_mode(syncm),
        .receive_enable(rxen), .transmit_enable(txen), .ser_clock_drive(sck_drv),
        .ser_transmit_data(txd), .ser_clock_sense(sck_sense), .ser_receive_data(rxd),
        .ext_interrupt5(ei5), .ext_interrupt4(ei4), .port_pin_i(pin_i),
        .port_pin_o(pin_o), .port_pin_oe(pin_oe), .pullup_on(pull_on)
    );
    pcio_pin_model pcio_pin_model_inst (
        .aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pullup_on(pull_on),
        .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_i)
    );

    // ****************************************
    // clock, timeout and verdict
    // ****************************************
    initial begin
        forever #5 aclk = ~aclk;
    end
    // hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // compare and bus tasks
    // ****************************************
    task automatic cmp_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp_pin(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_reg(name, {24'h0, exp}, {24'h0, got});
    endtask
    task automatic wait_n(input int k);
        repeat (k) @(negedge aclk);
    endtask
    // write; ready and valid seen at the negedge equal their rising-edge values
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        logic awt, wt, bt;
        bt = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int n = 0; n < 100 && !bt; n++) begin
            @(negedge aclk);
            awt = s_axi_awvalid & s_axi_awready;
            wt = s_axi_wvalid & s_axi_wready;
            bt = s_axi_bvalid & s_axi_bready;
            if (bt) cmp_reg("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
            @(posedge aclk);
            if (awt) s_axi_awvalid <= 1'h0;
            if (wt) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        if (!bt) err_count++;
    endtask
    task automatic axi_rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er,
                          input string name);
        logic art, rt;
        rt = 1'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int n = 0; n < 100 && !rt; n++) begin
            @(negedge aclk);
            art = s_axi_arvalid & s_axi_arready;
            rt = s_axi_rvalid & s_axi_rready;
            if (rt) cmp_reg(name, ed, s_axi_rdata);
            if (rt) cmp_reg("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
            @(posedge aclk);
            if (art) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        if (!rt) err_count++;
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        wait_n(1);
        cmp_pin("oe reset", 8'h00, pin_oe);
        cmp_pin("pull reset", 8'h00, pull_on);
        axi_rd(pcio_pkg::OFS_PULLUP, 32'h0, OK, "pullup reset");
        axi_rd(pcio_pkg::OFS_OPEN_DRN, 32'h0, OK, "open drain reset");
        axi_rd(pcio_pkg::OFS_OUT_DATA, 32'h0, OK, "data reset");
        axi_rd(pcio_pkg::OFS_DIRECTION, {24'h0, pcio_pkg::DIR_READ_VAL}, OK, "dir read");
        @(posedge aclk);
        ext_en <= 8'hff;
        ext_val <= 8'ha5;
        wait_n(3);
        axi_rd(pcio_pkg::OFS_READBACK, 32'ha5, OK, "readback pins");
        // mixed direction: data bits on outputs, pins on inputs
        axi_wr(pcio_pkg::OFS_DIRECTION, 32'hf0, OK);
        axi_wr(pcio_pkg::OFS_OUT_DATA, 32'h3c, OK);
        @(posedge aclk);
        ext_en <= 8'h0f;
        ext_val <= 8'h5a;
        wait_n(3);
        cmp_pin("oe gpio", 8'hf0, pin_oe);
        cmp_pin("drive gpio", 8'h30, pin_o & 8'hf0);
        axi_rd(pcio_pkg::OFS_READBACK, 32'h3a, OK, "mixed readback");
        axi_wr(pcio_pkg::OFS_READBACK, 32'hff, OK);
        axi_rd(pcio_pkg::OFS_OUT_DATA, 32'h3c, OK, "data after ro write");
        cmp_pin("oe after ro write", 8'hf0, pin_oe);
        // pull-ups and open drain
        axi_wr(pcio_pkg::OFS_PULLUP, 32'hff, OK);
        axi_rd(pcio_pkg::OFS_PULLUP, 32'hff, OK, "pullup rw");
        cmp_pin("pull inputs only", 8'h0f, pull_on);
        axi_wr(pcio_pkg::OFS_OPEN_DRN, 32'hff, OK);
        axi_rd(pcio_pkg::OFS_OPEN_DRN, 32'hff, OK, "open drain rw");
        cmp_pin("oe open drain", 8'hc0, pin_oe);
        cmp_pin("low open drain", 8'h00, pin_o & 8'hc0);
        cmp_pin("pull open drain", 8'h0f, pull_on);
        axi_wr(pcio_pkg::OFS_OPEN_DRN, 32'h00, OK);
        cmp_pin("oe push pull", 8'hf0, pin_oe);
        cmp_pin("high push pull", 8'h30, pin_o & 8'hf0);
        axi_wr(5'h14, 32'hff, pcio_pkg::RESP_SLVERR);
        axi_rd(5'h14, 32'h0, pcio_pkg::RESP_SLVERR, "unmapped read");
        // serial functions override direction on each channel
        axi_wr(pcio_pkg::OFS_DIRECTION, 32'hff, OK);
        axi_wr(pcio_pkg::OFS_OUT_DATA, 32'h00, OK);
        for (int ch = 0; ch < 2; ch++) begin
            b = 3 * ch;
            @(posedge aclk);
            txen[ch] <= 1'h1;
            txd[ch] <= 1'h1;
            rxen[ch] <= 1'h1;
            ceh[ch] <= 1'h1;
            ext_en <= 8'h06 << b;
            ext_val <= 8'h06 << b;
            wait_n(3);
            cmp_pin("ser oe in", 8'h01 << b, pin_oe & (8'h07 << b));
            cmp_pin("tx drive", 8'h01 << b, pin_o & (8'h01 << b));
            cmp_pin("ser in high", 8'h03, {6'h0, sck_sense[ch], rxd[ch]});
            cmp_pin("ser pull off", 8'h00, pull_on & (8'h07 << b));
            @(posedge aclk);
            ext_val <= 8'h00;
            txd[ch] <= 1'h0;
            wait_n(3);
            cmp_pin("ser in low", 8'h00, {6'h0, sck_sense[ch], rxd[ch]});
            cmp_pin("tx low", 8'h00, pin_o & (8'h01 << b));
            @(posedge aclk);
            ext_en <= 8'h00;
            ceh[ch] <= 1'h0;
            cel[ch] <= 1'h1;
            sck_drv[ch] <= 1'h1;
            wait_n(1);
            cmp_pin("clk out low en", 8'h04 << b, pin_oe & pin_o & (8'h04 << b));
            @(posedge aclk);
            cel[ch] <= 1'h0;
            syncm[ch] <= 1'h1;
            sck_drv[ch] <= 1'h0;
            wait_n(1);
            cmp_pin("clk out sync", 8'h04 << b, pin_oe & (8'h04 << b));
            cmp_pin("clk sync drive", 8'h00, pin_o & (8'h04 << b));
            @(posedge aclk);
            syncm[ch] <= 1'h0;
            txen[ch] <= 1'h0;
            rxen[ch] <= 1'h0;
            sck_drv[ch] <= 1'h0;
            wait_n(1);
            cmp_pin("gpio back oe", 8'h07 << b, pin_oe & (8'h07 << b));
            cmp_pin("gpio back data", 8'h00, pin_o & (8'h07 << b));
        end
        // interrupt inputs follow pins 5 and 2 as general inputs
        axi_wr(pcio_pkg::OFS_DIRECTION, 32'h00, OK);
        @(posedge aclk);
        ext_en <= 8'h24;
        ext_val <= 8'h04;
        wait_n(3);
        cmp_pin("irq pin2 high", 8'h01, {6'h0, ei5, ei4});
        @(posedge aclk);
        ext_val <= 8'h20;
        wait_n(3);
        cmp_pin("irq pin5 high", 8'h02, {6'h0, ei5, ei4});
        // clock enable low freezes the synchroniser
        @(posedge aclk);
        ce <= 1'h0;
        ext_val <= 8'h04;
        wait_n(3);
        cmp_pin("irq frozen", 8'h02, {6'h0, ei5, ei4});
        @(posedge aclk);
        ce <= 1'h1;
        wait_n(3);
        cmp_pin("irq resumed", 8'h01, {6'h0, ei5, ei4});
        complete_run();
    end
endmodule
`default_nettype wire
